/* File: gpt_defines.svh */
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

// Register byte offsets on the bus
`define GPT_OFF_CTRL     8'h00
`define GPT_OFF_COUNT    8'h04
`define GPT_OFF_PERIOD   8'h08
`define GPT_OFF_STATUS   8'h0C

// Reset values
`define GPT_CTRL_RST     16'h0000
`define GPT_COUNT_RST    16'h0000
`define GPT_PERIOD_RST   16'hFFFF

// Writable control bits: 15, 13, 6, 5:4, 2, 1
`define GPT_CTRL_MASK    16'hA076

// Status register: sticky match flag position
`define GPT_STAT_FLAG    0

// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define GPT_PS_LIM_1     8'h00
`define GPT_PS_LIM_8     8'h07
`define GPT_PS_LIM_64    8'h3F
`define GPT_PS_LIM_256   8'hFF

// Bus responses
`define GPT_RESP_OKAY    2'b00
`define GPT_RESP_SLVERR  2'b10

`endif

/* File: gpt_pkg.sv */
package gpt_pkg;

   // Counting source, decoded from the control fields
   typedef enum logic [1:0] {
      GPT_MODE_TIMER,
      GPT_MODE_GATED,
      GPT_MODE_SYNC,
      GPT_MODE_ASYNC
   } gpt_mode_t;

   // Control register laid out bit for bit
   typedef struct packed {
      logic       timer_enable_bit;        // Bit 15
      logic       rsv14;
      logic       idle_stop_bit;           // Bit 13
      logic [5:0] rsv12_7;
      logic       gate_accumulate_enable;  // Bit 6
      logic [1:0] prescale_select;         // Bits 5:4
      logic       rsv3;
      logic       ext_sync_select;         // Bit 2
      logic       clock_source_select;     // Bit 1
      logic       rsv0;
   } gpt_ctrl_t;

endpackage

/* File: gpt_pin_sync.sv */
`timescale 1ns/10ps

// Two-stage synchroniser with edge detection on the settled level
module gpt_pin_sync (
   input  wire logic i_sys_clk,
   input  wire logic i_nrst,
   input  wire logic i_ce,
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);

   logic meta_q;  // First stage, read only by the second
   logic sync_q;  // Settled level
   logic last_q;  // Settled level one cycle late

   // Shift chain, frozen with the clock enable
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else if (i_ce) begin
         meta_q <= i_pin;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Edges seen only on settled flops
   assign o_level = sync_q;
   assign o_rise  = sync_q & ~last_q;
   assign o_fall  = ~sync_q & last_q;

endmodule // gpt_pin_sync

/* File: gpt_timer.sv */
`timescale 1ns/10ps
`include "gpt_defines.svh"

// Behaviour
// - Timer mode counts cycles, wraps at period
// - Idle with stop bit halts counting
// - Sync mode counts resynchronised external rising edges
// - Async mode counts raw external rising edges
// - Async mode also halts in Idle
// - Gated mode counts cycles while gate high
// - Two-bit prescaler: 1, 8, 64, 256
// - Count write or disable clears prescaler
// - Disabled timer leaves prescaler untouched
// - Control write leaves count unchanged
// - Event on period match and gate fall
// - Sleep: only enabled async external keeps counting
// - Sync bit: 0 async, 1 sync
module gpt_timer #(
   parameter int ADDR_W = 8  // Bus address width
) (
   input  wire logic              i_sys_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_ce,
   input  wire logic              i_cpu_idle,
   input  wire logic              i_cpu_sleep,
   input  wire logic              i_ext_clock_gate_pin,
   input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
   input  wire logic              i_s_axi_awvalid,
   output logic                   o_s_axi_awready,
   input  wire logic [31:0]       i_s_axi_wdata,
   input  wire logic [3:0]        i_s_axi_wstrb,
   input  wire logic              i_s_axi_wvalid,
   output logic                   o_s_axi_wready,
   output logic [1:0]             o_s_axi_bresp,
   output logic                   o_s_axi_bvalid,
   input  wire logic              i_s_axi_bready,
   input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
   input  wire logic              i_s_axi_arvalid,
   output logic                   o_s_axi_arready,
   output logic [31:0]            o_s_axi_rdata,
   output logic [1:0]             o_s_axi_rresp,
   output logic                   o_s_axi_rvalid,
   input  wire logic              i_s_axi_rready,
   output logic [15:0]            o_count,
   output logic                   o_period_event,
   output logic                   o_period_match_flag
);

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   // Is an offset one of ours
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == ADDR_W'(`GPT_OFF_CTRL))  || (a == ADDR_W'(`GPT_OFF_COUNT)) ||
                  (a == ADDR_W'(`GPT_OFF_PERIOD)) || (a == ADDR_W'(`GPT_OFF_STATUS));
   endfunction

   gpt_pkg::gpt_ctrl_t ctrl_q;       // Control register
   logic [15:0]        count_q;      // Counter
   logic [15:0]        period_q;     // Period register
   logic [7:0]         ps_q;         // Prescaler counter
   logic               flag_q;       // Sticky match flag
   logic               event_q;      // Event pulse
   logic               pin_q;        // Raw pin, one cycle late
   logic               aw_v_q;       // Write address held
   logic               w_v_q;        // Write data held
   logic [ADDR_W-1:0]  aw_addr_q;    // Held write address
   logic [31:0]        w_data_q;     // Held write data
   logic [3:0]         w_strb_q;     // Held write strobes
   logic               bvalid_q;     // Write response pending
   logic [1:0]         bresp_q;      // Write response code
   logic               rvalid_q;     // Read data pending
   logic [1:0]         rresp_q;      // Read response code
   logic [31:0]        rdata_q;      // Read data

   gpt_pkg::gpt_mode_t mode;         // Decoded source
   logic               gate_lvl;     // Synchronised pin level
   logic               sync_rise;    // Synchronised rising edge
   logic               sync_fall;    // Synchronised falling edge
   logic               raw_rise;     // Unsynchronised rising edge
   logic               running;      // Not halted by enable, Idle or Sleep
   logic               src;          // Source edge or cycle
   logic               in_tick;      // Prescaler input tick
   logic [7:0]         ps_lim;       // Prescaler terminal count
   logic               pre_tick;     // Prescaled tick to counter
   logic               do_wr;        // Register write this cycle
   logic               ctrl_wr;      // Control register written
   logic               count_wr;     // Count register written
   logic               period_wr;    // Period register written
   logic               stat_clr;     // Flag clear by software
   logic               ps_clr;       // Prescaler clear
   logic               wrap;         // Count returns to zero
   logic               gate_fall;    // End of an accumulation
   gpt_pkg::gpt_ctrl_t ctrl_new;     // Incoming control value

   // Pin conditioning for sync and gated modes
   gpt_pin_sync u_pin_sync (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_ce      (i_ce),
      .i_pin     (i_ext_clock_gate_pin),
      .o_level   (gate_lvl),
      .o_rise    (sync_rise),
      .o_fall    (sync_fall)
   );

   // Source select from control fields
   always_comb begin
      if (!ctrl_q.clock_source_select) begin
         mode = ctrl_q.gate_accumulate_enable ? gpt_pkg::GPT_MODE_GATED
                                              : gpt_pkg::GPT_MODE_TIMER;
      end else begin
         mode = ctrl_q.ext_sync_select ? gpt_pkg::GPT_MODE_SYNC
                                       : gpt_pkg::GPT_MODE_ASYNC;
      end
   end

   // Halt conditions; only async external survives Sleep
   assign running = ctrl_q.timer_enable_bit
                  && !(i_cpu_idle && ctrl_q.idle_stop_bit)
                  && !(i_cpu_sleep && mode != gpt_pkg::GPT_MODE_ASYNC);

   // Async edge uses the raw pin with no synchroniser delay
   assign raw_rise = i_ext_clock_gate_pin & ~pin_q;

   // Per-mode source
   always_comb begin
      unique case (mode)
         gpt_pkg::GPT_MODE_TIMER: src = 1'b1;
         gpt_pkg::GPT_MODE_GATED: src = gate_lvl;
         gpt_pkg::GPT_MODE_SYNC:  src = sync_rise;
         gpt_pkg::GPT_MODE_ASYNC: src = raw_rise;
      endcase
   end

   assign in_tick = running && src;

   // Prescale ratio decode
   always_comb begin
      unique case (ctrl_q.prescale_select)
         2'h0: ps_lim = `GPT_PS_LIM_1;
         2'h1: ps_lim = `GPT_PS_LIM_8;
         2'h2: ps_lim = `GPT_PS_LIM_64;
         2'h3: ps_lim = `GPT_PS_LIM_256;
      endcase
   end

   // At or past the limit: a smaller ratio picked mid-count must not lap all 256 steps
   assign pre_tick = in_tick && (ps_q >= ps_lim);

   // Register write decode
   assign do_wr     = aw_v_q && w_v_q;
   assign ctrl_wr   = do_wr && aw_addr_q == ADDR_W'(`GPT_OFF_CTRL);
   assign count_wr  = do_wr && aw_addr_q == ADDR_W'(`GPT_OFF_COUNT);
   assign period_wr = do_wr && aw_addr_q == ADDR_W'(`GPT_OFF_PERIOD);
   assign stat_clr  = do_wr && aw_addr_q == ADDR_W'(`GPT_OFF_STATUS)
                    && w_strb_q[0] && w_data_q[`GPT_STAT_FLAG];
   assign ctrl_new  = merge16(ctrl_q, w_data_q, w_strb_q) & `GPT_CTRL_MASK;

   // Prescaler only clears while its clock runs, i.e. while enabled
   assign ps_clr = ctrl_q.timer_enable_bit
                 && (count_wr || (ctrl_wr && !ctrl_new.timer_enable_bit));

   assign wrap      = pre_tick && (count_q == period_q) && !count_wr;
   assign gate_fall = ctrl_q.timer_enable_bit && mode == gpt_pkg::GPT_MODE_GATED && sync_fall;

   // Control and period registers; control write never touches count
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         ctrl_q   <= `GPT_CTRL_RST;
         period_q <= `GPT_PERIOD_RST;
      end else if (i_ce) begin
         if (ctrl_wr) begin
            ctrl_q <= ctrl_new;
         end
         if (period_wr) begin
            period_q <= merge16(period_q, w_data_q, w_strb_q);
         end
      end
   end

   // Prescaler counter
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         ps_q <= 8'h00;
      end else if (i_ce) begin
         if (ps_clr) begin
            ps_q <= 8'h00;
         end else if (in_tick) begin
            ps_q <= pre_tick ? 8'h00 : 8'(ps_q + 8'h01);
         end
      end
   end

   // Counter; a software write beats a tick in the same cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         count_q <= `GPT_COUNT_RST;
      end else if (i_ce) begin
         if (count_wr) begin
            count_q <= merge16(count_q, w_data_q, w_strb_q);
         end else if (pre_tick) begin
            count_q <= (count_q == period_q) ? 16'h0000 : 16'(count_q + 16'h0001);
         end
      end
   end

   // Event pulse and sticky flag; set wins over clear
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         event_q <= 1'b0;
         flag_q  <= 1'b0;
         pin_q   <= 1'b0;
      end else if (i_ce) begin
         event_q <= wrap || gate_fall;
         pin_q   <= i_ext_clock_gate_pin;
         if (wrap || gate_fall) begin
            flag_q <= 1'b1;
         end else if (stat_clr) begin
            flag_q <= 1'b0;
         end
      end
   end

   // Write channels: address and data taken in either order
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         aw_v_q    <= 1'b0;
         w_v_q     <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `GPT_RESP_OKAY;
      end else if (i_ce) begin
         if (o_s_axi_awready && i_s_axi_awvalid) begin
            aw_v_q    <= 1'b1;
            aw_addr_q <= i_s_axi_awaddr;
         end
         if (o_s_axi_wready && i_s_axi_wvalid) begin
            w_v_q    <= 1'b1;
            w_data_q <= i_s_axi_wdata;
            w_strb_q <= i_s_axi_wstrb;
         end
         if (do_wr) begin
            aw_v_q   <= 1'b0;
            w_v_q    <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= is_mapped(aw_addr_q) ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
         end else if (bvalid_q && i_s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read channel: one read in flight, data from a register
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         rvalid_q <= 1'b0;
         rresp_q  <= `GPT_RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else if (i_ce) begin
         if (o_s_axi_arready && i_s_axi_arvalid) begin
            rvalid_q <= 1'b1;
            rresp_q  <= is_mapped(i_s_axi_araddr) ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
            unique case (i_s_axi_araddr)
               ADDR_W'(`GPT_OFF_CTRL):   rdata_q <= {16'h0000, ctrl_q};
               ADDR_W'(`GPT_OFF_COUNT):  rdata_q <= {16'h0000, count_q};
               ADDR_W'(`GPT_OFF_PERIOD): rdata_q <= {16'h0000, period_q};
               ADDR_W'(`GPT_OFF_STATUS): rdata_q <= {31'h0000_0000, flag_q};
               default:                  rdata_q <= 32'h0000_0000;
            endcase
         end else if (rvalid_q && i_s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Readies drop with the clock enable so no beat is lost
   assign o_s_axi_awready     = i_ce && !aw_v_q && !bvalid_q;
   assign o_s_axi_wready      = i_ce && !w_v_q && !bvalid_q;
   assign o_s_axi_arready     = i_ce && !rvalid_q;
   assign o_s_axi_bvalid      = bvalid_q;
   assign o_s_axi_bresp       = bresp_q;
   assign o_s_axi_rvalid      = rvalid_q;
   assign o_s_axi_rresp       = rresp_q;
   assign o_s_axi_rdata       = rdata_q;
   assign o_count             = count_q;
   assign o_period_event      = event_q;
   assign o_period_match_flag = flag_q;

   // Checks; a frozen cycle aborts any attempt in flight
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst || !i_ce);

   property p_wrap;
      pre_tick && !count_wr && count_q == period_q |=> count_q == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("count did not wrap at period");

   property p_inc;
      pre_tick && !count_wr && count_q != period_q |=> count_q == $past(count_q) + 16'h0001;
   endproperty
   a_inc: assert property (p_inc) else $error("count did not advance");

   property p_idle;
      i_cpu_idle && ctrl_q.idle_stop_bit |-> !in_tick;
   endproperty
   a_idle: assert property (p_idle) else $error("tick while idle-stopped");

   property p_async_idle;
      mode == gpt_pkg::GPT_MODE_ASYNC && i_cpu_idle && ctrl_q.idle_stop_bit && !count_wr
         |=> $stable(count_q);
   endproperty
   a_async_idle: assert property (p_async_idle) else $error("async count moved in idle");

   property p_sync;
      running && mode == gpt_pkg::GPT_MODE_SYNC |-> in_tick == sync_rise;
   endproperty
   a_sync: assert property (p_sync) else $error("sync tick mismatch");

   property p_async;
      running && mode == gpt_pkg::GPT_MODE_ASYNC && i_ext_clock_gate_pin && !pin_q |-> in_tick;
   endproperty
   a_async: assert property (p_async) else $error("async edge missed");

   property p_gate;
      mode == gpt_pkg::GPT_MODE_GATED && !gate_lvl |-> !in_tick;
   endproperty
   a_gate: assert property (p_gate) else $error("gated tick with gate low");

   property p_ps;
      in_tick && !ps_clr && ps_q < ps_lim |=> ps_q == $past(ps_q) + 8'h01 ##0 !$past(pre_tick);
   endproperty
   a_ps: assert property (p_ps) else $error("prescaler step wrong");

   property p_ps_clr;
      ps_clr |=> ps_q == 8'h00;
   endproperty
   a_ps_clr: assert property (p_ps_clr) else $error("prescaler not cleared");

   property p_ps_off;
      !ctrl_q.timer_enable_bit |=> $stable(ps_q);
   endproperty
   a_ps_off: assert property (p_ps_off) else $error("prescaler moved while disabled");

   property p_ctrl_wr;
      ctrl_wr && !pre_tick |=> $stable(count_q);
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write changed count");

   property p_event;
      (wrap || gate_fall) |=> o_period_event && o_period_match_flag;
   endproperty
   a_event: assert property (p_event) else $error("event or flag missing");

   property p_pulse;
      o_period_event |-> $past(wrap || gate_fall);
   endproperty
   a_pulse: assert property (p_pulse) else $error("event without cause");

   property p_sleep;
      i_cpu_sleep && mode != gpt_pkg::GPT_MODE_ASYNC |-> !in_tick;
   endproperty
   a_sleep: assert property (p_sleep) else $error("tick in sleep");

   property p_sel;
      ctrl_q.clock_source_select |-> (mode == gpt_pkg::GPT_MODE_SYNC) == ctrl_q.ext_sync_select;
   endproperty
   a_sel: assert property (p_sel) else $error("sync select decode wrong");

   c_wrap: cover property (wrap);
   c_gate_fall: cover property (gate_fall);
   c_sleep_tick: cover property (i_cpu_sleep && in_tick);
   c_ps_clr: cover property (ps_clr && ps_q != 8'h00);

endmodule // gpt_timer

/* File: gpt_ext_src.sv */
`timescale 1ns/10ps

// Far-side source for the clock / gate pin: a burst of rising edges or one gate pulse
module gpt_ext_src #(
   parameter int HALF = 3  // Cycles per clock half period
) (
   input  wire logic       i_sys_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_start,
   input  wire logic       i_gate,
   input  wire logic [7:0] i_num,
   output logic            o_pin,
   output logic            o_busy
);
   logic [8:0] left_q;  // Remaining toggles or high cycles
   logic [3:0] tick_q;  // Half-period counter
   logic       gate_q;  // Burst kind

   // Pin sequencer; pin stands low between bursts, no free-running clock
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_pin  <= 1'b0;
         o_busy <= 1'b0;
         left_q <= 9'h000;
         tick_q <= 4'h0;
         gate_q <= 1'b0;
      end else if (!o_busy) begin
         o_pin <= 1'b0;
         if (i_start) begin
            // First rising edge at once; odd toggle count ends low
            o_busy <= 1'b1;
            o_pin  <= 1'b1;
            gate_q <= i_gate;
            tick_q <= 4'h0;
            left_q <= i_gate ? {1'b0, i_num} : {i_num, 1'b0} - 9'h001;
         end
      end else if (gate_q) begin
         // Gate held high for the requested cycles
         if (left_q == 9'h001) begin
            o_busy <= 1'b0;
            o_pin  <= 1'b0;
         end
         left_q <= left_q - 9'h001;
      end else if (tick_q == 4'(HALF - 1)) begin
         tick_q <= 4'h0;
         o_pin  <= ~o_pin;
         left_q <= left_q - 9'h001;
         if (left_q == 9'h001) begin
            o_busy <= 1'b0;
         end
      end else begin
         tick_q <= tick_q + 4'h1;
      end
   end
endmodule  // gpt_ext_src

/* File: testbench.sv */
`timescale 1ns/10ps
`include "gpt_defines.svh"

module testbench;
   logic        sys_clk   = 1'b0;   // 250 MHz system clock
   logic        nrst      = 1'b0;   // Active-low reset
   logic        ce        = 1'b1;   // Clock enable
   logic        idle      = 1'b0;   // Processor Idle
   logic        sleep     = 1'b0;   // Processor Sleep
   logic        pin;                // From the far-side source
   logic [7:0]  awaddr    = 8'h00;
   logic        awvalid   = 1'b0;
   logic        awready;
   logic [31:0] wdata     = 32'h0000_0000;
   logic [3:0]  wstrb     = 4'h0;
   logic        wvalid    = 1'b0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready    = 1'b0;
   logic [7:0]  araddr    = 8'h00;
   logic        arvalid   = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready    = 1'b0;
   logic [15:0] count;              // Live counter
   logic        evt;                // Event pulse
   logic        flag;               // Sticky flag
   logic        ext_start = 1'b0;
   logic        ext_gate  = 1'b0;
   logic [7:0]  ext_num   = 8'h00;
   logic        ext_busy;
   logic [31:0] rd_v;               // Last read data
   logic [1:0]  rsp;                // Last response
   logic [15:0] c0;                 // Snapshot of the count
   int          bad_count = 0;
   int          tests_run = 0;
   int          c;

   // Clock
   always #2 sys_clk = ~sys_clk;

   gpt_timer #(.ADDR_W(8)) gpt_timer_i (
      .i_sys_clk(sys_clk), .i_nrst(nrst), .i_ce(ce), .i_cpu_idle(idle),
      .i_cpu_sleep(sleep), .i_ext_clock_gate_pin(pin),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_count(count),
      .o_period_event(evt), .o_period_match_flag(flag));

   gpt_ext_src #(.HALF(3)) gpt_ext_src_i (
      .i_sys_clk(sys_clk), .i_nrst(nrst), .i_start(ext_start), .i_gate(ext_gate),
      .i_num(ext_num), .o_pin(pin), .o_busy(ext_busy));

   // Verdict and end of run
   task complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Case-equality compare
   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bus write; address and data channels released independently
   task wr(input logic [7:0] a, input logic [31:0] d);
      int   n;
      logic aw_ok;
      logic w_ok;
      @(posedge sys_clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hF;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      n     = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (!aw_ok && awready === 1'b1) begin
            awvalid <= 1'b0;
            aw_ok = 1'b1;
         end
         if (!w_ok && wready === 1'b1) begin
            wvalid <= 1'b0;
            w_ok = 1'b1;
         end
      end while (!(aw_ok && w_ok && bvalid === 1'b1) && n < 100);
      bready <= 1'b0;
      rsp = bresp;
      check(n < 100, 1'b1);
   endtask

   // Bus read
   task rd(input logic [7:0] a);
      int   n;
      logic ar_ok;
      @(posedge sys_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      ar_ok = 1'b0;
      n     = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (!ar_ok && arready === 1'b1) begin
            arvalid <= 1'b0;
            ar_ok = 1'b1;
         end
      end while (!(ar_ok && rvalid === 1'b1) && n < 100);
      rready <= 1'b0;
      rd_v = rdata;
      rsp  = rresp;
      check(n < 100, 1'b1);
   endtask

   // Cycles until the next event pulse, bounded
   task wait_evt;
      c = 0;
      do begin
         @(posedge sys_clk);
         c++;
      end while (evt !== 1'b1 && c < 3000);
   endtask

   // One burst from the far side, waited out
   task ext(input logic g, input logic [7:0] n);
      int k;
      @(posedge sys_clk);
      ext_start <= 1'b1;
      ext_gate  <= g;
      ext_num   <= n;
      @(posedge sys_clk);
      ext_start <= 1'b0;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (ext_busy !== 1'b0 && k < 500);
   endtask

   // Reset contents and an unmapped place
   task t_reset;
      rd(`GPT_OFF_CTRL);
      check(rd_v, 32'h0000_0000);
      rd(`GPT_OFF_PERIOD);
      check(rd_v, 32'h0000_FFFF);
      rd(8'h10);
      check(rd_v, 32'h0000_0000);
      check(rsp, `GPT_RESP_SLVERR);
      wr(8'h10, 32'h0000_FFFF);
      check(rsp, `GPT_RESP_SLVERR);
   endtask

   // Wrap spacing at every prescale ratio, then flag clear
   task t_timer_ps;
      int ratio[4] = '{1, 8, 64, 256};
      wr(`GPT_OFF_PERIOD, 32'h0000_0003);
      for (int i = 0; i < 4; i++) begin
         wr(`GPT_OFF_CTRL, 32'h0000_8000 | (32'(i) << 4));
         wait_evt();
         wait_evt();
         check(c, 4 * ratio[i]);
         @(posedge sys_clk);
         check(evt, 1'b0);
         check(flag, 1'b1);
      end
      wr(`GPT_OFF_CTRL, 32'h0000_0000);
      wr(`GPT_OFF_STATUS, 32'h0000_0001);
      rd(`GPT_OFF_STATUS);
      check(rd_v, 32'h0000_0000);
   endtask

   // Control write keeps count; count write restarts the prescaler
   task t_ctrl_count;
      wr(`GPT_OFF_COUNT, 32'h0000_1234);
      wr(`GPT_OFF_CTRL, 32'h0000_0030);
      rd(`GPT_OFF_COUNT);
      check(rd_v, 32'h0000_1234);
      wr(`GPT_OFF_PERIOD, 32'h0000_FFFF);
      wr(`GPT_OFF_CTRL, 32'h0000_8010);
      repeat (13) @(posedge sys_clk);
      wr(`GPT_OFF_COUNT, 32'h0000_0100);
      // Edge at which an uncleared prescaler would already have stepped
      repeat (7) @(posedge sys_clk);
      check(count, 16'h0100);
      repeat (3) @(posedge sys_clk);
      check(count, 16'h0101);
   endtask

   // Idle with and without the stop bit
   task t_idle;
      wr(`GPT_OFF_COUNT, 32'h0000_0000);
      wr(`GPT_OFF_CTRL, 32'h0000_A000);
      idle <= 1'b1;
      repeat (3) @(posedge sys_clk);
      c0 = count;
      repeat (20) @(posedge sys_clk);
      check(count, c0);
      idle <= 1'b0;
      repeat (5) @(posedge sys_clk);
      check(count !== c0, 1'b1);
      wr(`GPT_OFF_CTRL, 32'h0000_8000);
      idle <= 1'b1;
      repeat (3) @(posedge sys_clk);
      c0 = count;
      repeat (10) @(posedge sys_clk);
      check(count - c0, 16'h000A);
      idle <= 1'b0;
   endtask

   // External counting: sync, async, Idle and Sleep cases
   task t_ext;
      wr(`GPT_OFF_CTRL, 32'h0000_8006);
      wr(`GPT_OFF_COUNT, 32'h0000_0000);
      ext(1'b0, 8'h05);
      repeat (5) @(posedge sys_clk);
      check(count, 16'h0005);
      wr(`GPT_OFF_CTRL, 32'h0000_8002);
      wr(`GPT_OFF_COUNT, 32'h0000_0000);
      ext(1'b0, 8'h05);
      repeat (2) @(posedge sys_clk);
      check(count, 16'h0005);
      wr(`GPT_OFF_CTRL, 32'h0000_A002);
      idle <= 1'b1;
      ext(1'b0, 8'h03);
      repeat (2) @(posedge sys_clk);
      check(count, 16'h0005);
      idle  <= 1'b0;
      sleep <= 1'b1;
      wr(`GPT_OFF_CTRL, 32'h0000_8002);
      ext(1'b0, 8'h04);
      repeat (2) @(posedge sys_clk);
      check(count, 16'h0009);
      wr(`GPT_OFF_CTRL, 32'h0000_8006);
      ext(1'b0, 8'h04);
      repeat (5) @(posedge sys_clk);
      check(count, 16'h0009);
      sleep <= 1'b0;
   endtask

   // Gated accumulation and the gate-fall event
   task t_gate;
      wr(`GPT_OFF_CTRL, 32'h0000_8040);
      wr(`GPT_OFF_COUNT, 32'h0000_0000);
      wr(`GPT_OFF_STATUS, 32'h0000_0001);
      ext(1'b1, 8'h0A);
      wait_evt();
      check(c < 10, 1'b1);
      check(count, 16'h000A);
      check(flag, 1'b1);
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset();
      t_timer_ps();
      t_ctrl_count();
      t_idle();
      t_ext();
      t_gate();
      complete_run();
   end

   // Hang guard, well past the expected run length
   initial begin
      #100_000;
      bad_count++;
      complete_run();
   end
endmodule  // testbench
